// *** rtl/port9_mux_cfg.svh ***
`ifndef PORT9_MUX_CFG_SVH
`define PORT9_MUX_CFG_SVH

// apb byte addresses
`define P9_OFS_FSEL 8'h00
`define P9_OFS_FEXP 8'h04
`define P9_OFS_MODE 8'h08
`define P9_OFS_PU 8'h0C
`define P9_OFS_PU_LO 8'h10
`define P9_OFS_PU_HI 8'h14

// reset values and implemented bits
`define P9_RST_VAL 16'h0000
`define P9_FEXP_MASK 16'h20FF

`endif

// *** rtl/port9_mux_pkg.sv ***
package port9_mux_pkg;

  // per-pin routing decision
  typedef enum logic [2:0] {
    RT_GPIO,
    RT_OFF,
    RT_ALT_A,
    RT_ALT_B,
    RT_ALT_C
  } route_t;

  // peripheral signals that may drive pins
  typedef struct packed {
    logic programmable_clock_out;
    logic serial2_clock_out;
    logic serial2_clock_oe;
    logic serial2_data_out;
    logic serial1_clock_out;
    logic serial1_clock_oe;
    logic serial1_data_out;
    logic timer_p2_ch0_out;
    logic timer_p2_ch1_out;
    logic [3:0] timer_q1_out;
    logic uart1_transmit_out;
  } periph_drive_t;

  // pin levels handed to peripherals
  typedef struct packed {
    logic ext_interrupt_in_6;
    logic ext_interrupt_in_5;
    logic ext_interrupt_in_4;
    logic serial2_clock_in;
    logic serial2_data_in;
    logic serial1_clock_in;
    logic serial1_data_in;
    logic timer_p2_ch0_capture_in;
    logic timer_p2_ch1_capture_in;
    logic [3:0] timer_q1_in;
    logic key_return_in_7;
    logic key_return_in_6;
    logic uart1_receive_in;
  } periph_sense_t;

endpackage

// *** rtl/port9_pin_decode.sv ***
`timescale 1ns/1ps
module port9_pin_decode import port9_mux_pkg::*; #(
  parameter int PIN = 0
) (
  // per-pin control bits
  input wire logic mode,
  input wire logic fsel,
  input wire logic fexp,
  // decoded route
  output route_t route
);

  logic [1:0] pair;

  assign pair = {fexp, fsel};

  // decode expansion/select pair for this pin
  always_comb begin
    route = RT_OFF;
    if (!mode) begin
      route = RT_GPIO;
    end else begin
      case (PIN)
        15, 14, 12, 11, 10, 9, 8: begin
          route = fsel ? RT_ALT_A : RT_OFF;
        end
        13, 5, 4, 3, 2, 1, 0: begin
          case (pair)
            2'b01: route = RT_ALT_A;
            2'b10: route = RT_ALT_B;
            default: route = RT_OFF;
          endcase
        end
        7: begin
          case (pair)
            2'b01: route = RT_ALT_A;
            2'b10: route = RT_ALT_B;
            2'b11: route = RT_ALT_C;
            default: route = RT_OFF;
          endcase
        end
        6: begin
          case (pair)
            2'b10: route = RT_ALT_B;
            2'b11: route = RT_ALT_C;
            default: route = RT_OFF;
          endcase
        end
        default: route = RT_OFF;
      endcase
    end
  end

endmodule // port9_pin_decode

// *** rtl/port9_function_select_pullup.sv ***
`timescale 1ns/1ps
`include "port9_mux_cfg.svh"
module port9_function_select_pullup import port9_mux_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // gpio side of each pin
  input wire logic [15:0] gpio_out,
  input wire logic [15:0] gpio_oe,
  output logic [15:0] gpio_in,
  // peripheral side
  input wire periph_drive_t periph_drive,
  output periph_sense_t periph_sense,
  // pads
  input wire logic [15:0] pad_in,
  output logic [15:0] pad_out,
  output logic [15:0] pad_oe,
  output logic [15:0] pullup_en
);

  // control and pull-up registers
  logic [15:0] fsel_r, fsel_nxt;
  logic [15:0] fexp_r, fexp_nxt;
  logic [15:0] mode_r, mode_nxt;
  logic [15:0] pu_r, pu_nxt;
  // bus answer
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  // pad synchroniser and pin outputs
  logic [15:0] sync1_r, sync1_nxt;
  logic [15:0] sync2_r, sync2_nxt;
  logic [15:0] pad_out_r, pad_out_nxt;
  logic [15:0] pad_oe_r, pad_oe_nxt;
  periph_sense_t sense_r, sense_nxt;
  // per-pin decode and bus helpers
  route_t route [16];
  logic [7:0] addr;
  logic commit;
  logic hit;

  // offset decode and the edge at which a transfer completes
  assign addr = paddr[7:0];
  assign commit = psel && penable && pready_r;

  // one decoder per pin
  for (genvar i = 0; i < 16; i++) begin : g_pin
    port9_pin_decode #(
      .PIN(i)
    ) u_dec (
      .mode(mode_r[i]),
      .fsel(fsel_r[i]),
      .fexp(fexp_r[i]),
      .route(route[i])
    );
  end

  // apply byte lanes 0 and 1 to a 16-bit register
  function automatic logic [15:0] lane_wr(
    input logic [15:0] cur,
    input logic [31:0] wd,
    input logic [3:0] st
  );
    logic [15:0] res;
    res = cur;
    if (st[0]) begin
      res[7:0] = wd[7:0];
    end
    if (st[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  // apb answer: one cycle into the access phase
  always_comb begin
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    hit = 1'b1;
    if (psel && penable && !pready_r) begin
      pready_nxt = 1'b1;
      prdata_nxt = 32'h0000_0000;
      case (addr)
        `P9_OFS_FSEL: prdata_nxt[15:0] = fsel_r;
        `P9_OFS_FEXP: prdata_nxt[15:0] = fexp_r;
        `P9_OFS_MODE: prdata_nxt[15:0] = mode_r;
        `P9_OFS_PU: prdata_nxt[15:0] = pu_r;
        `P9_OFS_PU_LO: prdata_nxt[7:0] = pu_r[7:0];
        `P9_OFS_PU_HI: prdata_nxt[7:0] = pu_r[15:8];
        default: hit = 1'b0;
      endcase
      // unmapped offsets answer with an error and read zero
      pslverr_nxt = !hit;
    end
  end

  // bus answer registers: pready and pslverr last one cycle, prdata holds its value until the next access
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // register writes land only at the edge that sees pready high
  always_comb begin
    fsel_nxt = fsel_r;
    fexp_nxt = fexp_r;
    mode_nxt = mode_r;
    pu_nxt = pu_r;
    if (commit && pwrite) begin
      case (addr)
        `P9_OFS_FSEL: begin
          fsel_nxt = lane_wr(fsel_r, pwdata, pstrb);
        end
        `P9_OFS_FEXP: begin
          // only bits 13 and 7..0 of the expansion register exist
          fexp_nxt = lane_wr(fexp_r, pwdata, pstrb) & `P9_FEXP_MASK;
        end
        `P9_OFS_MODE: begin
          mode_nxt = lane_wr(mode_r, pwdata, pstrb);
        end
        `P9_OFS_PU: begin
          pu_nxt = lane_wr(pu_r, pwdata, pstrb);
        end
        `P9_OFS_PU_LO: begin
          if (pstrb[0]) pu_nxt[7:0] = pwdata[7:0];
        end
        `P9_OFS_PU_HI: begin
          // byte view bits 7..0 land on register bits 15..8
          if (pstrb[0]) pu_nxt[15:8] = pwdata[7:0];
        end
        default: ;
      endcase
    end
  end

  // control and pull-up registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fsel_r <= `P9_RST_VAL;
      fexp_r <= `P9_RST_VAL;
      mode_r <= `P9_RST_VAL;
      pu_r <= `P9_RST_VAL;
    end else begin
      fsel_r <= fsel_nxt;
      fexp_r <= fexp_nxt;
      mode_r <= mode_nxt;
      pu_r <= pu_nxt;
    end
  end

  // pad synchroniser: two stages before any logic reads a pad
  always_comb begin
    sync1_nxt = pad_in;
    sync2_nxt = sync1_r;
  end

  // synchroniser stages, only the second is read by logic
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  // pad drive: gpio in port mode, the chosen peripheral otherwise
  always_comb begin
    int ch;
    ch = 0;
    pad_out_nxt = 16'h0000;
    pad_oe_nxt = 16'h0000;
    // port mode: gpio data and enable pass through
    for (int i = 0; i < 16; i++) begin
      if (route[i] == RT_GPIO) begin
        pad_out_nxt[i] = gpio_out[i];
        pad_oe_nxt[i] = gpio_oe[i];
      end
    end
    // programmable clock output on pin 13
    if (route[13] == RT_ALT_B) begin
      pad_out_nxt[13] = periph_drive.programmable_clock_out;
      pad_oe_nxt[13] = 1'b1;
    end
    // serial channel 2: clock drives only while the unit enables it
    if (route[12] == RT_ALT_A) begin
      pad_out_nxt[12] = periph_drive.serial2_clock_out;
      pad_oe_nxt[12] = periph_drive.serial2_clock_oe;
    end
    if (route[11] == RT_ALT_A) begin
      pad_out_nxt[11] = periph_drive.serial2_data_out;
      pad_oe_nxt[11] = 1'b1;
    end
    // serial channel 1: clock drives only while the unit enables it
    if (route[9] == RT_ALT_A) begin
      pad_out_nxt[9] = periph_drive.serial1_clock_out;
      pad_oe_nxt[9] = periph_drive.serial1_clock_oe;
    end
    if (route[8] == RT_ALT_A) begin
      pad_out_nxt[8] = periph_drive.serial1_data_out;
      pad_oe_nxt[8] = 1'b1;
    end
    // timer p2 outputs
    if (route[7] == RT_ALT_C) begin
      pad_out_nxt[7] = periph_drive.timer_p2_ch0_out;
      pad_oe_nxt[7] = 1'b1;
    end
    if (route[6] == RT_ALT_C) begin
      pad_out_nxt[6] = periph_drive.timer_p2_ch1_out;
      pad_oe_nxt[6] = 1'b1;
    end
    // timer q1 outputs: pins 5,4,3,2 carry channels 0,3,2,1
    for (int p = 2; p < 6; p++) begin
      ch = (p == 5) ? 0 : p - 1;
      if (route[p] == RT_ALT_B) begin
        pad_out_nxt[p] = periph_drive.timer_q1_out[ch];
        pad_oe_nxt[p] = 1'b1;
      end
    end
    // uart channel 1 transmit on pin 0
    if (route[0] == RT_ALT_B) begin
      pad_out_nxt[0] = periph_drive.uart1_transmit_out;
      pad_oe_nxt[0] = 1'b1;
    end
  end

  // peripheral inputs see the pad only while routed, else 0
  always_comb begin
    int ch;
    ch = 0;
    sense_nxt = '0;
    // external interrupt inputs
    sense_nxt.ext_interrupt_in_6 = (route[15] == RT_ALT_A) && sync2_r[15];
    sense_nxt.ext_interrupt_in_5 = (route[14] == RT_ALT_A) && sync2_r[14];
    sense_nxt.ext_interrupt_in_4 = (route[13] == RT_ALT_A) && sync2_r[13];
    // serial channel 2 clock and data in
    sense_nxt.serial2_clock_in = (route[12] == RT_ALT_A) && sync2_r[12];
    sense_nxt.serial2_data_in = (route[10] == RT_ALT_A) && sync2_r[10];
    // serial channel 1 clock and data in
    sense_nxt.serial1_clock_in = (route[9] == RT_ALT_A) && sync2_r[9];
    sense_nxt.serial1_data_in = (route[7] == RT_ALT_A) && sync2_r[7];
    // timer p2 capture inputs
    sense_nxt.timer_p2_ch0_capture_in = (route[7] == RT_ALT_B) && sync2_r[7];
    sense_nxt.timer_p2_ch1_capture_in = (route[6] == RT_ALT_B) && sync2_r[6];
    // timer q1 inputs: pins 5,4,3,2 carry channels 0,3,2,1
    for (int p = 2; p < 6; p++) begin
      ch = (p == 5) ? 0 : p - 1;
      sense_nxt.timer_q1_in[ch] = (route[p] == RT_ALT_A) && sync2_r[p];
    end
    // key return and uart channel 1 receive
    sense_nxt.key_return_in_7 = (route[1] == RT_ALT_A || route[1] == RT_ALT_B) && sync2_r[1];
    sense_nxt.uart1_receive_in = (route[1] == RT_ALT_B) && sync2_r[1];
    sense_nxt.key_return_in_6 = (route[0] == RT_ALT_A) && sync2_r[0];
  end

  // registered pad drive
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pad_out_r <= 16'h0000;
      pad_oe_r <= 16'h0000;
    end else begin
      pad_out_r <= pad_out_nxt;
      pad_oe_r <= pad_oe_nxt;
    end
  end

  // registered peripheral inputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sense_r <= '0;
    end else begin
      sense_r <= sense_nxt;
    end
  end

  // bus answer
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  // pin side
  assign gpio_in = sync2_r;
  assign pad_out = pad_out_r;
  assign pad_oe = pad_oe_r;
  assign pullup_en = pu_r;
  // peripheral side
  assign periph_sense = sense_r;

endmodule // port9_function_select_pullup

// *** sim/port9_fsp_asserts.sv ***
`timescale 1ns/1ps
module port9_fsp_asserts #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pads
  input wire logic [15:0] pad_oe,
  input wire logic [15:0] pullup_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // bus answer timing
  chk_ready_slot: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  chk_ready_cause: assert property (pready |-> psel && penable && $past(penable))
    else $error("ready outside access");
  chk_err_decode: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h14))
    else $error("error flag wrong");
  chk_err_read: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  // pull-up register views
  chk_pu_full: assert property (pready && pwrite && paddr == 8'h0C && pstrb == 4'hF
    |=> pullup_en == $past(pwdata[15:0])) else $error("pull-up write lost");
  chk_pu_high: assert property (pready && pwrite && paddr == 8'h14 && pstrb[0]
    |=> pullup_en == {$past(pwdata[7:0]), $past(pullup_en[7:0])}) else $error("upper view wrong");
  chk_pu_low: assert property (pready && pwrite && paddr == 8'h10 && pstrb[0]
    |=> pullup_en == {$past(pullup_en[15:8]), $past(pwdata[7:0])}) else $error("lower view wrong");
  chk_reset_clear: assert property ($fell(sys_rst) |-> pullup_en == 16'h0 && pad_oe == 16'h0)
    else $error("reset state wrong");
  // main scenarios
  cover property (pready && pslverr);
  cover property (pready && pwrite && paddr == 8'h14);
  cover property ($rose(pad_oe[13]));
endmodule // port9_fsp_asserts

bind port9_function_select_pullup port9_fsp_asserts #(.ADDR_W(ADDR_W)) u_chk (.ref_clk, .sys_rst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pad_oe, .pullup_en);

// *** sim/test_port9_function_select_pullup.sv ***
`timescale 1ns/1ps
module test_port9_function_select_pullup import port9_mux_pkg::*;;
  typedef struct packed {logic [15:0] fsel, fexp, mode, goe, oe, sns;} row_t;
  logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 0;
  logic [15:0] gpio_oe = 0, pad_in = 16'hFFFF, gpio_in, pad_out, pad_oe, pullup_en;
  periph_sense_t periph_sense;
  int miscompares = 0, comparisons = 0;
  // select, expansion, mode, gpio enable, expected enables, expected sense
  row_t rows [5] = '{'{16'hDFC0, 16'h20FF, 16'hFFFF, 16'h0, 16'h3BFD, 16'hDC05},
    '{16'hFFBF, 16'h0040, 16'hFFFF, 16'h0, 16'h1B00, 16'hFEFE},
    '{16'hFF7F, 16'h20FF, 16'hFFFF, 16'h0, 16'h1B40, 16'hDD00},
    '{16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0, 16'h0},
    '{16'hFFFF, 16'h0000, 16'h0000, 16'hA5A5, 16'hA5A5, 16'h0}};
  // clock
  always #2 ref_clk = ~ref_clk;
  port9_function_select_pullup dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_out(16'hFFFF), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
    .periph_drive(periph_drive_t'(14'h3FFF)), .periph_sense(periph_sense), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pullup_en(pullup_en));
  // verdict and end of run
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for pready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      $display("FAIL %0t no ready", $time);
      end_sim;
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 0;
    for (int a = 0; a < 16; a += 4) begin
      apb(0, 8'(a), 32'h0, 4'hF);
      chk(rd[15:0], 16'h0);
    end
    chk(pullup_en, 16'h0);
    chk(pad_oe, 16'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1, 8'h08, 32'h0, 4'hF);
      apb(1, 8'h00, {16'h0, rows[i].fsel}, 4'hF);
      apb(1, 8'h04, {16'h0, rows[i].fexp}, 4'hF);
      apb(1, 8'h08, {16'h0, rows[i].mode}, 4'hF);
      gpio_oe <= rows[i].goe;
      repeat (4) @(posedge ref_clk);
      chk(pad_oe, rows[i].oe);
      chk(periph_sense, rows[i].sns);
      chk(pad_out & rows[i].oe, rows[i].oe);
      chk(gpio_in, 16'hFFFF);
    end
    $display("routing test done");
    apb(1, 8'h04, 32'hFFFF, 4'hF);
    apb(0, 8'h04, 32'h0, 4'hF);
    chk(rd[15:0], 16'h20FF);
    apb(1, 8'h0C, 32'h1234ABCD, 4'hF);
    @(posedge ref_clk);
    chk(pullup_en, 16'hABCD);
    apb(1, 8'h14, 32'h5A, 4'h1);
    apb(0, 8'h14, 32'h0, 4'hF);
    chk(rd[15:0], 16'h005A);
    chk(pullup_en, 16'h5ACD);
    apb(1, 8'h10, 32'h3C, 4'h1);
    apb(1, 8'h0C, 32'hFF00, 4'h2);
    apb(0, 8'h0C, 32'h0, 4'hF);
    chk(rd[15:0], 16'hFF3C);
    apb(1, 8'h18, 32'hFFFF, 4'hF);
    chk({15'h0, er}, 16'h1);
    apb(0, 8'h18, 32'h0, 4'hF);
    chk(rd[15:0], 16'h0);
    chk(pullup_en, 16'hFF3C);
    $display("register test done");
    // port mode passes the synchronised pad level, peripherals see 0
    pad_in <= 16'h5A5A;
    repeat (3) @(posedge ref_clk);
    chk(gpio_in, 16'h5A5A);
    chk(periph_sense, 16'h0);
    chk(pad_oe, 16'hA5A5);
    $display("pad level test done");
    // mid-run reset clears every register and the pad drive
    sys_rst <= 1;
    repeat (3) @(posedge ref_clk);
    chk(pad_oe, 16'h0);
    chk(pullup_en, 16'h0);
    sys_rst <= 0;
    for (int a = 0; a < 16; a += 4) begin
      apb(0, 8'(a), 32'h0, 4'hF);
      chk(rd[15:0], 16'h0);
    end
    chk(pad_oe, 16'hA5A5);
    $display("mid-run reset test done");
    end_sim;
  end
endmodule // test_port9_function_select_pullup
